// File: gp_sequencer_pkg.sv
package gp_sequencer_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int POS_W  = 13;
  localparam int FIELD_W = 4;
  localparam int NUM_TOG = 4;

  // printed offsets are register indices; byte address is four times
  localparam int IDX_TRIGGER   = 32'h50;
  localparam int IDX_COUNT_CFG = 32'h51;
  localparam int IDX_OUT_CFG   = 32'h52;
  localparam int IDX_TOG_BASE  = 32'h54;
  localparam int IDX_STATUS    = 32'h58;

  localparam logic [ADDR_W-1:0] ADDR_TRIGGER   = ADDR_W'(IDX_TRIGGER * 4);
  localparam logic [ADDR_W-1:0] ADDR_COUNT_CFG = ADDR_W'(IDX_COUNT_CFG * 4);
  localparam logic [ADDR_W-1:0] ADDR_OUT_CFG   = ADDR_W'(IDX_OUT_CFG * 4);
  localparam logic [ADDR_W-1:0] ADDR_TOG_BASE  = ADDR_W'(IDX_TOG_BASE * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = ADDR_W'(IDX_STATUS * 4);

  // output configuration field positions
  localparam int PROTO_LSB   = 0;
  localparam int POL_LSB     = 4;
  localparam int OE_LSB      = 6;
  localparam int LUT_SEL_LSB = 8;
  localparam int LUT_LSB     = 10;

  localparam logic [2:0] ACT_IDLE       = 3'h0;
  localparam logic [2:0] ACT_ONCE       = 3'h1;
  localparam logic [2:0] ACT_REPEAT     = 3'h2;
  localparam logic [2:0] ACT_DELAYED    = 3'h3;
  localparam logic [2:0] ACT_FORCE_IDLE = 3'h7;

  localparam logic [1:0] PROTO_IDLE   = 2'h0;
  localparam logic [1:0] PROTO_MANUAL = 2'h1;
  localparam logic [1:0] PROTO_LINKED = 2'h2;
  localparam logic [1:0] PROTO_REPEAT = 2'h3;

  localparam logic [3:0] LUT_RESET   = 4'h0;
  localparam logic [3:0] COUNT_FIRST = 4'h1;

  typedef struct packed {
    logic [FIELD_W-1:0] field;
    logic [POS_W-1:0]   line;
    logic [POS_W-1:0]   pixel;
  } toggle_type;

  typedef struct packed {
    logic [FIELD_W-1:0] count;
    logic               running;
    logic               first_pass;
  } count_state_type;

  typedef enum logic [1:0] {CNT_IDLE, CNT_DELAY, CNT_RUN} counter_mode_type;

endpackage

// File: field_counter.sv
`timescale 1ns/1ps
`default_nettype none
module field_counter
  import gp_sequencer_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_nrst,
  input  wire logic               i_vsync,
  input  wire logic [2:0]         i_action,
  input  wire logic [FIELD_W-1:0] i_max,
  input  wire logic [FIELD_W-1:0] i_delay,
  output var  count_state_type    o_state
);

  typedef struct packed {
    counter_mode_type   mode;
    logic               repeating;
    logic               first_pass;
    logic [FIELD_W-1:0] count;
    logic [FIELD_W-1:0] delay_left;
  } cnt_reg_type;

  cnt_reg_type s;
  cnt_reg_type next_s;

  always_comb begin
    next_s = s;
    if (i_vsync) begin
      if (i_action == ACT_FORCE_IDLE) begin
        next_s.mode = CNT_IDLE;
      end else if (i_action == ACT_ONCE || i_action == ACT_REPEAT) begin
        next_s.mode       = CNT_RUN;
        next_s.count      = COUNT_FIRST;
        next_s.first_pass = 1'b1;
        next_s.repeating  = (i_action == ACT_REPEAT);
      end else if (i_action == ACT_DELAYED) begin
        next_s.repeating  = 1'b0;
        next_s.first_pass = 1'b1;
        next_s.count      = COUNT_FIRST;
        next_s.delay_left = i_delay;
        next_s.mode = (i_delay == '0) ? CNT_RUN : CNT_DELAY;
      end else begin
        // idle and test codes leave a running sequence alone
        unique case (s.mode)
          CNT_RUN: begin
            if (s.count >= i_max) begin
              if (s.repeating) begin
                next_s.count      = COUNT_FIRST;
                next_s.first_pass = 1'b0;
              end else begin
                next_s.mode = CNT_IDLE;
              end
            end else begin
              next_s.count = s.count + 1'b1;
            end
          end
          CNT_DELAY: begin
            if (s.delay_left <= 4'h1) begin
              next_s.mode = CNT_RUN;
            end else begin
              next_s.delay_left = s.delay_left - 1'b1;
            end
          end
          CNT_IDLE: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s <= '{mode: CNT_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign o_state = '{count: s.count, running: (s.mode == CNT_RUN),
                     first_pass: s.first_pass};

endmodule
`default_nettype wire

// File: gp_channel.sv
`timescale 1ns/1ps
`default_nettype none
module gp_channel
  import gp_sequencer_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_vsync,
  input  wire logic [POS_W-1:0] i_line,
  input  wire logic [POS_W-1:0] i_pixel,
  input  wire logic [1:0]       i_proto,
  input  wire logic             i_pol,
  input  wire toggle_type [1:0] i_tog,
  input  wire count_state_type  i_count,
  output logic                  o_level
);

  typedef struct packed {
    logic [1:0] active_proto;
    logic       level;
  } chan_reg_type;

  chan_reg_type s;
  chan_reg_type next_s;
  logic [1:0]   hit;

  always_comb begin
    next_s = s;
    hit    = '0;
    for (int t = 0; t < 2; t++) begin
      if (i_tog[t].line == i_line && i_tog[t].pixel == i_pixel) begin
        unique case (s.active_proto)
          PROTO_MANUAL: hit[t] = 1'b1;
          PROTO_LINKED: hit[t] = i_count.running &&
                                 i_count.first_pass &&
                                 i_count.count == i_tog[t].field;
          PROTO_REPEAT: hit[t] = i_count.running &&
                                 i_count.count == i_tog[t].field;
          PROTO_IDLE:   hit[t] = 1'b0;
        endcase
      end
    end
    if (i_vsync) begin
      // protocol written during a field only acts from the next one
      next_s.active_proto = i_proto;
      if (i_proto inside {PROTO_IDLE, PROTO_MANUAL} ||
          s.active_proto == PROTO_IDLE) begin
        next_s.level = i_pol;
      end
    end else begin
      next_s.level = s.level ^ hit[0] ^ hit[1];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_level = s.level;

endmodule
`default_nettype wire

// File: gp_output_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module gp_output_sequencer
  import gp_sequencer_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              I_NRST,
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire logic [ADDR_W-1:0] I_PADDR,
  input  wire logic [DATA_W-1:0] I_PWDATA,
  output logic      [DATA_W-1:0] O_PRDATA,
  output logic                   O_PREADY,
  output logic                   O_PSLVERR,
  input  wire logic              I_VERTICAL_SYNC,
  input  wire logic [POS_W-1:0]  I_LINE,
  input  wire logic [POS_W-1:0]  I_PIXEL,
  output logic                   O_AUX_OUTPUT_ONE,
  output logic                   O_AUX_OUTPUT_TWO,
  output logic      [1:0]        O_AUX_OUTPUT_EN
);

  typedef struct packed {
    logic [2:0]                 trigger;
    logic [FIELD_W-1:0]         max_count;
    logic [FIELD_W-1:0]         delay;
    logic [1:0][1:0]            proto;
    logic [1:0]                 pol;
    logic [1:0]                 oe;
    logic [1:0]                 lut_sel;
    logic [3:0]                 lut;
    toggle_type [NUM_TOG-1:0]   tog;
    logic [DATA_W-1:0]          prdata;
    logic                       pready;
    logic                       pslverr;
    logic [1:0]                 out;
  } top_state_type;

  top_state_type     s;
  top_state_type     next_s;
  count_state_type   cnt;
  logic [1:0]        level;
  logic [DATA_W-1:0] rd;
  logic              hit;
  logic              wr;

  field_counter u_counter (
    .i_clk   (I_CLK),
    .i_nrst  (I_NRST),
    .i_vsync (I_VERTICAL_SYNC),
    .i_action(s.trigger),
    .i_max   (s.max_count),
    .i_delay (s.delay),
    .o_state (cnt)
  );

  // toggles 0,1 belong to output one and 2,3 to output two
  for (genvar g = 0; g < 2; g++) begin : gen_chan
    gp_channel u_chan (
      .i_clk  (I_CLK),
      .i_nrst (I_NRST),
      .i_vsync(I_VERTICAL_SYNC),
      .i_line (I_LINE),
      .i_pixel(I_PIXEL),
      .i_proto(s.proto[g]),
      .i_pol  (s.pol[g]),
      .i_tog  (s.tog[2*g+1 -: 2]),
      .i_count(cnt),
      .o_level(level[g])
    );
  end

  always_comb begin
    next_s = s;
    rd     = '0;
    hit    = 1'b1;
    wr     = I_PSEL && I_PENABLE && s.pready && I_PWRITE && !s.pslverr;

    unique case (I_PADDR)
      ADDR_TRIGGER:   rd = DATA_W'(s.trigger);
      ADDR_COUNT_CFG: rd = DATA_W'({s.delay, s.max_count});
      ADDR_OUT_CFG:   rd = DATA_W'({s.lut, s.lut_sel, s.oe, s.pol, s.proto});
      ADDR_STATUS:    rd = DATA_W'({s.out, cnt.first_pass, cnt.running,
                                    cnt.count});
      default: begin
        hit = 1'b0;
        for (int i = 0; i < NUM_TOG; i++) begin
          if (I_PADDR == ADDR_TOG_BASE + ADDR_W'(4 * i)) begin
            hit = 1'b1;
            rd  = DATA_W'(s.tog[i]);
          end
        end
      end
    endcase

    // answer is prepared in the setup cycle so the access needs no wait
    if (I_PSEL && !I_PENABLE) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = !hit;
      next_s.prdata  = hit ? rd : '0;
    end else begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
    end

    // trigger is consumed by the counter at this same edge
    if (I_VERTICAL_SYNC) begin
      next_s.trigger = ACT_IDLE;
    end

    // a write in the sync cycle wins over the self-clear
    if (wr) begin
      unique case (I_PADDR)
        ADDR_TRIGGER:   next_s.trigger = I_PWDATA[2:0];
        ADDR_COUNT_CFG: begin
          next_s.max_count = I_PWDATA[3:0];
          next_s.delay     = I_PWDATA[7:4];
        end
        ADDR_OUT_CFG: begin
          next_s.proto   = I_PWDATA[PROTO_LSB +: 4];
          next_s.pol     = I_PWDATA[POL_LSB +: 2];
          next_s.oe      = I_PWDATA[OE_LSB +: 2];
          next_s.lut_sel = I_PWDATA[LUT_SEL_LSB +: 2];
          next_s.lut     = I_PWDATA[LUT_LSB +: 4];
        end
        default: begin
          for (int i = 0; i < NUM_TOG; i++) begin
            if (I_PADDR == ADDR_TOG_BASE + ADDR_W'(4 * i)) begin
              next_s.tog[i] = I_PWDATA[$bits(toggle_type)-1:0];
            end
          end
        end
      endcase
    end

    for (int k = 0; k < 2; k++) begin
      next_s.out[k] = s.lut_sel[k] ? s.lut[{level[1], level[0]}]
                                   : level[k];
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      s <= '{trigger: ACT_IDLE, lut: LUT_RESET, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign O_PRDATA         = s.prdata;
  assign O_PREADY         = s.pready;
  assign O_PSLVERR        = s.pslverr;
  assign O_AUX_OUTPUT_ONE = s.out[0];
  assign O_AUX_OUTPUT_TWO = s.out[1];
  assign O_AUX_OUTPUT_EN  = s.oe;

endmodule
`default_nettype wire

// File: field_timing_model.sv
`timescale 1ns/1ps
`default_nettype none
module field_timing_model
  import gp_sequencer_pkg::*;
#(
  parameter int PIX = 16,
  parameter int LIN = 4
)
(
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  output logic                  o_vsync,
  output logic      [POS_W-1:0] o_line,
  output logic      [POS_W-1:0] o_pixel
);
  // a tiny raster keeps fields short; lines from LIN up and pixels from PIX up never match
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_line  <= '0;
      o_pixel <= '0;
    end else if (o_pixel == POS_W'(PIX - 1)) begin
      o_pixel <= '0;
      o_line  <= (o_line == POS_W'(LIN - 1)) ? '0 : o_line + 1'b1;
    end else begin
      o_pixel <= o_pixel + 1'b1;
    end
  end
  // one-cycle pulse opens every field
  assign o_vsync = i_nrst && o_line == '0 && o_pixel == '0;
endmodule
`default_nettype wire

// File: gp_output_sequencer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module gp_output_sequencer_chk
  import gp_sequencer_pkg::*;
(
  input wire logic              I_CLK,
  input wire logic              I_NRST,
  input wire logic              I_PSEL,
  input wire logic              I_PENABLE,
  input wire logic              I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [DATA_W-1:0] I_PWDATA,
  input wire logic [DATA_W-1:0] O_PRDATA,
  input wire logic              O_PREADY,
  input wire logic              O_PSLVERR,
  input wire logic              O_AUX_OUTPUT_ONE,
  input wire logic [1:0]        O_AUX_OUTPUT_EN
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  logic setup;
  logic wr_cfg;
  assign setup  = I_PSEL && !I_PENABLE;
  assign wr_cfg = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE
                  && I_PADDR == ADDR_OUT_CFG;
  ready_setup_a: assert property (setup |=> O_PREADY)
    else $error("no ready after setup");
  ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  idle_ready_a: assert property (!I_PSEL |=> !O_PREADY)
    else $error("ready without select");
  err_clean_a: assert property (
    O_PSLVERR |-> O_PREADY && O_PRDATA == '0)
    else $error("error without ready or with data");
  unmapped_err_a: assert property (
    setup && I_PADDR == 12'h14C |=> O_PSLVERR)
    else $error("unmapped access not refused");
  trigger_ok_a: assert property (
    setup && I_PADDR == ADDR_TRIGGER |=> !O_PSLVERR)
    else $error("trigger access refused");
  enable_cause_a: assert property (
    $changed(O_AUX_OUTPUT_EN) |-> $past(wr_cfg) || $past(wr_cfg, 2))
    else $error("enables moved without a write");
  enable_value_a: assert property (
    wr_cfg |-> ##2 O_AUX_OUTPUT_EN == $past(I_PWDATA[7:6], 2))
    else $error("enables differ from written value");
  cover property (wr_cfg);
  cover property (O_PSLVERR);
  cover property ($rose(O_AUX_OUTPUT_ONE));
endmodule
bind gp_output_sequencer gp_output_sequencer_chk chk_u (
  .I_CLK(I_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_AUX_OUTPUT_ONE(O_AUX_OUTPUT_ONE), .O_AUX_OUTPUT_EN(O_AUX_OUTPUT_EN)
);
`default_nettype wire

// File: gp_output_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gp_output_sequencer_tb
  import gp_sequencer_pkg::*;
;
  logic              clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic              vs, pready, pslverr, one, two;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata;
  logic [1:0]        en;
  logic [POS_W-1:0]  line, pixel;
  int                fails = 0, checks_done = 0;
  always #20 clk = ~clk;
  field_timing_model fm_u (.i_clk(clk), .i_nrst(nrst), .o_vsync(vs),
    .o_line(line), .o_pixel(pixel));
  gp_output_sequencer dut_u (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_VERTICAL_SYNC(vs), .I_LINE(line),
    .I_PIXEL(pixel), .O_AUX_OUTPUT_ONE(one), .O_AUX_OUTPUT_TWO(two),
    .O_AUX_OUTPUT_EN(en));
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // returns on the edge that closes raster position (l,p)
  task automatic at(input int l, p);
    @(posedge clk);
    while (!(line == POS_W'(l) && pixel == POS_W'(p))) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    // idle cycle keeps back-to-back calls from driving psel twice
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 0, q, e);
  endtask
  task automatic pin(input int l, p, input logic [1:0] e, input string nm);
    at(l, p);
    chk(nm, e, {two, one});
  endtask
  function automatic logic [31:0] tog(input int f, l, p);
    return {2'b00, 4'(f), 13'(l), 13'(p)};
  endfunction
  function automatic logic [31:0] cfgw(input logic [1:0] p1, p2, s,
                                       input logic [3:0] lut);
    return {18'h0, lut, s, 2'b11, 2'b00, p2, p1};
  endfunction
  task automatic idle_field;
    wr(ADDR_OUT_CFG, 0);
    at(0, 2); // protocol idle for a whole field
  endtask
  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    chk("reset pins", 0, {en, two, one});
    wr(ADDR_STATUS, 32'hFF);
    apb(1'b0, 12'h14C, 0, q, e);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, q);
    rd(ADDR_STATUS, q);
    chk("status read only", 0, q[7:0]);
    $display("test regs done");
  endtask
  task automatic t_manual;
    wr(ADDR_TOG_BASE, tog(1, 1, 2)); // field index one
    wr(ADDR_TOG_BASE + 4, tog(1, 2, 3));
    at(0, 2);
    wr(ADDR_OUT_CFG, cfgw(1, 0, 0, 0) | 32'h10); // starts high
    pin(1, 5, 0, "manual write field");
    pin(1, 5, 0, "manual first toggle");
    pin(3, 0, 1, "manual second toggle");
    pin(1, 5, 0, "manual repeats");
    at(0, 2);
    wr(ADDR_OUT_CFG, 0);
    at(0, 2);
    pin(1, 5, 0, "manual stopped");
    $display("test manual done");
  endtask
  task automatic t_linked;
    logic [31:0] q;
    wr(ADDR_COUNT_CFG, 32'h3);
    wr(ADDR_TOG_BASE, tog(2, 1, 2));
    wr(ADDR_TOG_BASE + 4, tog(3, 1, 2));
    wr(ADDR_OUT_CFG, cfgw(2, 0, 0, 0));
    wr(ADDR_TRIGGER, ACT_ONCE);
    pin(1, 5, 0, "linked count one");
    rd(ADDR_TRIGGER, q);
    chk("trigger cleared", 0, q[2:0]);
    pin(1, 5, 1, "linked count two");
    rd(ADDR_STATUS, q);
    chk("count two status", 32'h32, q[5:0]);
    pin(1, 5, 0, "linked count three");
    at(1, 5);
    rd(ADDR_STATUS, q);
    chk("single pass ends", 0, q[4]);
    idle_field();
    $display("test linked done");
  endtask
  task automatic t_repeat;
    wr(ADDR_COUNT_CFG, 32'h2);
    wr(ADDR_TOG_BASE, tog(1, 1, 2));
    wr(ADDR_TOG_BASE + 4, tog(2, 1, 2));
    wr(ADDR_TOG_BASE + 8, tog(1, 2, 2));
    wr(ADDR_TOG_BASE + 12, tog(5, 5, 5));
    wr(ADDR_OUT_CFG, cfgw(3, 2, 0, 0));
    wr(ADDR_TRIGGER, ACT_REPEAT);
    // the counter takes the trigger at the next sync only
    at(0, 2);
    pin(3, 0, 2'b11, "pass one count one");
    pin(3, 0, 2'b10, "pass one count two");
    pin(3, 0, 2'b11, "pass two count one");
    wr(ADDR_TRIGGER, ACT_FORCE_IDLE);
    pin(3, 0, 2'b11, "forced idle");
    idle_field();
    $display("test repeat done");
  endtask
  task automatic t_delay;
    wr(ADDR_COUNT_CFG, 32'h21);
    wr(ADDR_TOG_BASE, tog(1, 1, 2));
    wr(ADDR_OUT_CFG, cfgw(2, 0, 0, 0));
    wr(ADDR_TRIGGER, ACT_DELAYED);
    at(0, 2);
    pin(1, 5, 0, "delay field one");
    pin(1, 5, 0, "delay field two");
    pin(1, 5, 1, "delayed start");
    idle_field();
    $display("test delay done");
  endtask
  task automatic t_lut;
    logic [3:0] tbl [5] = '{4'h6, 4'h7, 4'h8, 4'hE, 4'h6};
    logic [1:0] own [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
    logic [1:0] s, e;
    wr(ADDR_TOG_BASE, tog(1, 1, 2));
    wr(ADDR_TOG_BASE + 4, tog(1, 3, 2));
    wr(ADDR_TOG_BASE + 8, tog(1, 0, 2));
    wr(ADDR_TOG_BASE + 12, tog(1, 2, 2));
    for (int i = 0; i < 5; i++) begin
      s = (i == 4) ? 2'b10 : 2'b01;
      at(0, 8);
      wr(ADDR_OUT_CFG, cfgw(1, 1, s, tbl[i]));
      for (int l = 0; l < 4; l++) begin
        e[0] = s[0] ? tbl[i][own[l]] : own[l][0];
        e[1] = s[1] ? tbl[i][own[l]] : own[l][1];
        pin(l, 8, e, "pair logic");
      end
    end
    chk("enables", 3, en);
    $display("test lut done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    t_regs();
    t_manual();
    t_linked();
    t_repeat();
    t_delay();
    t_lut();
    test_done();
  end
  initial begin
    repeat (6000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
